// ### src/rf_switch_pkg.sv
// constants and types for the rf switch register bank and its serial slave
package rf_switch_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PATH   = 8'h00;
    localparam logic [7:0] ADDR_SPARE  = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h1A;
    localparam logic [7:0] ADDR_TRIG   = 8'h1C;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_PATH  = 8'h00;
    localparam logic [7:0] RESET_SPARE = 8'h00;
    localparam logic [2:0] RESET_MASK  = 3'h0;
    localparam logic [6:1] RESET_FLAGS = 6'h00;
    localparam logic [3:0] DEFAULT_USID = 4'h8;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned SRST_BIT      = 7;
    localparam int unsigned FLAG_CMD_PAR  = 6;
    localparam int unsigned FLAG_LEN      = 5;
    localparam int unsigned FLAG_ADDR_PAR = 4;
    localparam int unsigned FLAG_DATA_PAR = 3;
    localparam int unsigned FLAG_RD_BAD   = 2;
    localparam int unsigned FLAG_WR_BAD   = 1;
    localparam int unsigned TRIG_LO       = 0;
    localparam int unsigned MASK_LO       = 3;
    localparam int unsigned TRIG_W        = 3;
    localparam int unsigned ROUTE_W       = 4;
    localparam logic [2:0]  MASK_ALL      = 3'h7;

    // ------------------------------------------------------------------
    // frame layout: slave id, payload byte, odd parity
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_SA_HI  = 12;
    localparam int unsigned FRAME_SA_LO  = 9;
    localparam int unsigned FRAME_PAY_HI = 8;
    localparam int unsigned FRAME_PAY_LO = 1;
    localparam logic [3:0]  CMD_FRAME_BITS  = 4'hD;
    localparam logic [3:0]  BYTE_FRAME_BITS = 4'h9;
    localparam logic [3:0]  RD_END_CNT      = 4'hA;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam int unsigned CMD_REG0_BIT = 7;
    localparam logic [2:0]  CMD_WR_TAG   = 3'h2;
    localparam logic [2:0]  CMD_RD_TAG   = 3'h3;
    localparam logic [7:0]  CMD_EXT_WR   = 8'h00;
    localparam logic [7:0]  CMD_EXT_RD   = 8'h20;

    // ------------------------------------------------------------------
    // one-hot routes
    // ------------------------------------------------------------------
    localparam logic [3:0] ROUTE_ISOLATE = 4'h0;
    localparam logic [3:0] ROUTE_ONE     = 4'h1;
    localparam logic [3:0] ROUTE_TWO     = 4'h2;
    localparam logic [3:0] ROUTE_THREE   = 4'h4;
    localparam logic [3:0] ROUTE_FOUR    = 4'h8;

    // ------------------------------------------------------------------
    // state types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RPARK, ST_RDATA, ST_DONE
    } link_state_t;

    typedef struct packed {
        link_state_t st;
        logic [3:0]  cnt;
        logic [12:0] sh;
        logic [7:0]  addr;
        logic        is_read;
        logic        rd_status;
        logic [8:0]  rd_word;
        logic        sclk_d;
        logic        sdata_d;
        logic [7:0]  path_select_reg;
        logic [7:0]  spare_scratch_reg;
        logic [7:0]  shadow_path;
        logic [7:0]  shadow_spare;
        logic [2:0]  trigger_disable_bits;
        logic [6:1]  flags;
        logic [3:0]  rf_en;
        logic        sdata_o;
        logic        sdata_oe;
    } core_state_t;

endpackage

// ### src/link_sync.sv
// two-flop synchroniser for link pins
`timescale 1ns/1ps
module link_sync #(
    parameter int unsigned W = 2
) (
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    input  wire logic [W-1:0] async_in,
    output logic [W-1:0]      sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // ------------------------------------------------------------------
    // next state: meta is read only by the stable stage
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt.meta   = async_in;
        s_nxt.stable = s_r.meta;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.stable;
endmodule

// ### src/rf_switch_regs.sv
// rf switch register bank with its two-wire serial slave
//
// Behaviour
// - path field is one-hot port select; zero isolates all and is reset.
// - path and spare registers belong to triggers zero to two.
// - writing one to status bit 7 starts a software reset.
// - software reset clears status and all user registers to reset values.
// - software reset bit always reads as zero.
// - command frame parity error sets status bit 6.
// - sequence of wrong bit or frame count sets status bit 5.
// - address frame parity error sets status bit 4.
// - data frame parity error sets status bit 3.
// - read to an unimplemented address sets status bit 2.
// - write to an unimplemented address sets status bit 1.
// - enabled trigger sends writes to shadows; setting trigger loads them, self-clears.
// - trigger mask bit disables trigger; direct write only when all masked.
// - reading the status register clears its flags after data returns.
`timescale 1ns/1ps
module rf_switch_regs
    import rf_switch_pkg::*;
#(
    parameter logic [3:0] USID = DEFAULT_USID
) (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        sclk_in,
    input  wire logic        sdata_in,
    output logic             sdata_out,
    output logic             sdata_oe_out,
    output logic [3:0]       rf_port_en_out
);
    core_state_t s;
    core_state_t s_nxt;
    logic [1:0]  pins_sync;
    logic        sclk_s;
    logic        sdata_s;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        ssc;
    logic        do_wr;
    logic [7:0]  wa;
    logic [7:0]  wd;
    logic        srst;
    logic        clr_ev;
    logic [6:1]  fset;

    // ------------------------------------------------------------------
    // pin synchroniser and edge detection
    // ------------------------------------------------------------------
    link_sync #(.W(2)) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({sclk_in, sdata_in}),
        .sync_out   (pins_sync)
    );

    assign sclk_s    = pins_sync[1];
    assign sdata_s   = pins_sync[0];
    assign sclk_rise = sclk_s & ~s.sclk_d;
    assign sclk_fall = ~sclk_s & s.sclk_d;
    // start condition: data pulse falls while clock is low
    assign ssc       = ~sdata_s & s.sdata_d & ~sclk_s & ~s.sdata_oe;

    function automatic logic addr_ok(input logic [7:0] a);
        return (a == ADDR_PATH) || (a == ADDR_SPARE) || (a == ADDR_STATUS) || (a == ADDR_TRIG);
    endfunction

    function automatic logic [7:0] read_mux(input core_state_t c, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_PATH:   v = c.path_select_reg;
            ADDR_SPARE:  v = c.spare_scratch_reg;
            ADDR_STATUS: v = {1'b0, c.flags, 1'b0};
            ADDR_TRIG:   v[MASK_LO +: TRIG_W] = c.trigger_disable_bits;
            default:     v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic [3:0] route(input logic [3:0] p);
        logic [3:0] r;
        r = ROUTE_ISOLATE;
        unique case (p)
            ROUTE_ONE, ROUTE_TWO, ROUTE_THREE, ROUTE_FOUR: r = p;
            default: r = ROUTE_ISOLATE;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // sequence decoder and register update
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt   = s;
        do_wr   = 1'b0;
        wa      = 8'h00;
        wd      = 8'h00;
        srst    = 1'b0;
        clr_ev  = 1'b0;
        fset    = '0;
        s_nxt.sclk_d  = sclk_s;
        s_nxt.sdata_d = sdata_s;
        if (sclk_fall) begin
            s_nxt.sh = {s.sh[11:0], sdata_s};
        end
        unique case (s.st)
            ST_IDLE: ;
            ST_CMD, ST_ADDR, ST_WDATA: begin
                if (sclk_fall) begin
                    s_nxt.cnt = s.cnt + 4'h1;
                end
            end
            ST_RPARK: begin
                if (sclk_rise) begin
                    s_nxt.st  = ST_RDATA;
                    s_nxt.cnt = 4'h0;
                end
            end
            ST_RDATA: begin
                if (sclk_rise && s.cnt != RD_END_CNT) begin
                    s_nxt.sdata_o  = s.rd_word[8]; // trailing zero is the park bit
                    s_nxt.sdata_oe = 1'b1;
                    s_nxt.rd_word  = {s.rd_word[7:0], 1'b0};
                    s_nxt.cnt      = s.cnt + 4'h1;
                end else if (sclk_fall && s.cnt == RD_END_CNT) begin
                    s_nxt.sdata_oe = 1'b0;
                    s_nxt.sdata_o  = 1'b0;
                    s_nxt.st       = ST_IDLE;
                    clr_ev         = s.rd_status;
                end
            end
            ST_DONE: begin
                if (sclk_fall) begin
                    if (s.cnt == 4'h0) begin
                        s_nxt.cnt = 4'h1;
                    end else begin
                        fset[FLAG_LEN] = 1'b1;
                        s_nxt.st       = ST_IDLE;
                    end
                end
            end
        endcase

        // complete frames
        if (s.st == ST_CMD && s_nxt.cnt == CMD_FRAME_BITS) begin
            s_nxt.cnt = 4'h0;
            s_nxt.st  = ST_IDLE;
            if (!(^s_nxt.sh)) begin
                fset[FLAG_CMD_PAR] = 1'b1;
            end else if (s_nxt.sh[FRAME_SA_HI:FRAME_SA_LO] == USID) begin
                wd = s_nxt.sh[FRAME_PAY_HI:FRAME_PAY_LO];
                if (wd[CMD_REG0_BIT]) begin
                    do_wr    = 1'b1;
                    wa       = ADDR_PATH;
                    wd[CMD_REG0_BIT] = 1'b0;
                    s_nxt.st = ST_DONE;
                end else if (wd[7:5] == CMD_WR_TAG || wd[7:5] == CMD_RD_TAG) begin
                    s_nxt.addr    = {3'h0, wd[4:0]};
                    s_nxt.is_read = wd[5];
                    s_nxt.st      = wd[5] ? ST_RPARK : ST_WDATA;
                end else if (wd == CMD_EXT_WR || wd == CMD_EXT_RD) begin
                    s_nxt.is_read = (wd == CMD_EXT_RD);
                    s_nxt.st      = ST_ADDR;
                end
            end
        end else if (s.st == ST_ADDR && s_nxt.cnt == BYTE_FRAME_BITS) begin
            s_nxt.cnt = 4'h0;
            if (!(^s_nxt.sh[8:0])) begin
                fset[FLAG_ADDR_PAR] = 1'b1;
                s_nxt.st = ST_IDLE;
            end else begin
                s_nxt.addr = s_nxt.sh[FRAME_PAY_HI:FRAME_PAY_LO];
                s_nxt.st   = s.is_read ? ST_RPARK : ST_WDATA;
            end
        end else if (s.st == ST_WDATA && s_nxt.cnt == BYTE_FRAME_BITS) begin
            s_nxt.cnt = 4'h0;
            s_nxt.st  = ST_DONE;
            if (!(^s_nxt.sh[8:0])) begin
                fset[FLAG_DATA_PAR] = 1'b1;
                s_nxt.st = ST_IDLE;
            end else if (addr_ok(s.addr)) begin
                do_wr = 1'b1;
                wa    = s.addr;
                wd    = s_nxt.sh[FRAME_PAY_HI:FRAME_PAY_LO];
            end else begin
                fset[FLAG_WR_BAD] = 1'b1;
            end
        end

        // latch read word when entering the park cycle
        if (s_nxt.st == ST_RPARK && s.st != ST_RPARK) begin
            s_nxt.rd_word   = {read_mux(s, s_nxt.addr), ~^read_mux(s, s_nxt.addr)};
            s_nxt.rd_status = (s_nxt.addr == ADDR_STATUS);
            fset[FLAG_RD_BAD] = !addr_ok(s_nxt.addr);
        end

        // start condition restarts; mid-sequence start is a length fault
        if (ssc) begin
            if (s.st != ST_IDLE && s.st != ST_DONE) begin
                fset[FLAG_LEN] = 1'b1;
            end
            s_nxt.st       = ST_CMD;
            s_nxt.cnt      = 4'h0;
            s_nxt.sdata_oe = 1'b0;
        end

        // register writes through trigger shadows
        if (do_wr) begin
            unique case (wa)
                ADDR_PATH: begin
                    if (s.trigger_disable_bits == MASK_ALL) begin
                        s_nxt.path_select_reg = wd;
                    end else begin
                        s_nxt.shadow_path = wd;
                    end
                end
                ADDR_SPARE: begin
                    if (s.trigger_disable_bits == MASK_ALL) begin
                        s_nxt.spare_scratch_reg = wd;
                    end else begin
                        s_nxt.shadow_spare = wd;
                    end
                end
                ADDR_STATUS: srst = wd[SRST_BIT];
                ADDR_TRIG: begin
                    s_nxt.trigger_disable_bits = wd[MASK_LO +: TRIG_W];
                    // mask updates before triggers fire; triggers never stored
                    if (|(wd[TRIG_LO +: TRIG_W] & ~wd[MASK_LO +: TRIG_W])) begin
                        s_nxt.path_select_reg   = s.shadow_path;
                        s_nxt.spare_scratch_reg = s.shadow_spare;
                    end
                end
                default: ;
            endcase
        end

        // software reset, read clear, then sets win
        if (srst) begin
            s_nxt.path_select_reg      = RESET_PATH;
            s_nxt.spare_scratch_reg    = RESET_SPARE;
            s_nxt.shadow_path          = RESET_PATH;
            s_nxt.shadow_spare         = RESET_SPARE;
            s_nxt.trigger_disable_bits = RESET_MASK;
            s_nxt.flags                = RESET_FLAGS;
        end else if (clr_ev) begin
            s_nxt.flags = RESET_FLAGS;
        end
        s_nxt.flags = s_nxt.flags | fset;
        s_nxt.rf_en = route(s_nxt.path_select_reg[ROUTE_W-1:0]);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s <= '{st: ST_IDLE, path_select_reg: RESET_PATH, spare_scratch_reg: RESET_SPARE,
                   shadow_path: RESET_PATH, shadow_spare: RESET_SPARE,
                   trigger_disable_bits: RESET_MASK, flags: RESET_FLAGS,
                   rf_en: ROUTE_ISOLATE, default: '0};
        end else begin
            s <= s_nxt;
        end
    end

    assign sdata_out      = s.sdata_o;
    assign sdata_oe_out   = s.sdata_oe;
    assign rf_port_en_out = s.rf_en;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_route_onehot;
        $onehot0(rf_port_en_out) && (rf_port_en_out == ROUTE_ISOLATE ||
            rf_port_en_out == s.path_select_reg[ROUTE_W-1:0]);
    endproperty
    a_route_onehot: assert property (p_route_onehot) else $error("route not one-hot");

    property p_soft_reset;
        (do_wr && wa == ADDR_STATUS && wd[SRST_BIT]) |=> (s.path_select_reg == RESET_PATH
            && s.spare_scratch_reg == RESET_SPARE && s.flags == RESET_FLAGS
            && rf_port_en_out == ROUTE_ISOLATE);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

    property p_status_bit7_zero;
        (s.st == ST_RPARK && s.rd_status) |-> !s.rd_word[8];
    endproperty
    a_status_bit7_zero: assert property (p_status_bit7_zero) else $error("reset bit read one");

    property p_cmd_parity;
        fset[FLAG_CMD_PAR] |=> s.flags[FLAG_CMD_PAR] && s.st == ST_IDLE;
    endproperty
    a_cmd_parity: assert property (p_cmd_parity) else $error("command parity flag missed");

    property p_len_err;
        (ssc && s.st inside {ST_CMD, ST_ADDR, ST_WDATA, ST_RPARK, ST_RDATA}) |=> s.flags[FLAG_LEN];
    endproperty
    a_len_err: assert property (p_len_err) else $error("length flag missed");

    property p_data_parity;
        (s.st == ST_WDATA && s_nxt.cnt == BYTE_FRAME_BITS && !(^s_nxt.sh[8:0]))
            |=> s.flags[FLAG_DATA_PAR] && s.path_select_reg == $past(s.path_select_reg);
    endproperty
    a_data_parity: assert property (p_data_parity) else $error("data parity not handled");

    property p_wr_bad;
        (s.st == ST_WDATA && s_nxt.cnt == BYTE_FRAME_BITS && (^s_nxt.sh[8:0])
            && !addr_ok(s.addr)) |=> s.flags[FLAG_WR_BAD];
    endproperty
    a_wr_bad: assert property (p_wr_bad) else $error("bad write address flag missed");

    property p_trig_load;
        (do_wr && wa == ADDR_TRIG && |(wd[TRIG_LO +: TRIG_W] & ~wd[MASK_LO +: TRIG_W]))
            |=> s.path_select_reg == $past(s.shadow_path);
    endproperty
    a_trig_load: assert property (p_trig_load) else $error("trigger did not load");

    property p_shadow_hold;
        (do_wr && wa == ADDR_PATH && s.trigger_disable_bits != MASK_ALL)
            |=> s.path_select_reg == $past(s.path_select_reg) && s.shadow_path == $past(wd);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("write bypassed shadow");

    property p_read_clear;
        (clr_ev && fset == '0) |=> s.flags == RESET_FLAGS;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

    property p_flag_sticky;
        (s.flags[FLAG_WR_BAD] && !clr_ev && !srst) |=> s.flags[FLAG_WR_BAD];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    c_direct_write: cover property (do_wr && wa == ADDR_PATH && s.trigger_disable_bits == MASK_ALL);
    c_trigger_load: cover property (do_wr && wa == ADDR_TRIG && |wd[TRIG_LO +: TRIG_W]);
    c_status_read:  cover property (clr_ev);
    c_soft_reset:   cover property (srst);
endmodule

// ### dv/serial_master_model.sv
// behavioural two-wire serial bus master facing the switch register bank
`timescale 1ns/1ps
module serial_master_model
    import rf_switch_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic sdata_in,
    output logic      sclk_out,
    output logic      sdata_out,
    output logic      sdata_oe_out
);
    localparam int HALF = 4;

    // link clock stands low between frames, master parks the line low
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        sdata_oe_out = 1'b1;
    end

    task automatic half_wait();
        repeat (HALF) @(negedge clk_in);
    endtask

    // launch on link clock rise, device takes it on the fall
    task automatic send_bit(input logic b);
        sdata_out = b;
        sclk_out = 1'b1;
        half_wait();
        sclk_out = 1'b0;
        half_wait();
    endtask

    task automatic send_bits(input logic [12:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            send_bit(v[i]);
        end
    endtask

    // data pulse while the link clock is low marks a new sequence
    task automatic start_seq();
        @(negedge clk_in);
        sdata_out = 1'b1;
        half_wait();
        sdata_out = 1'b0;
        half_wait();
    endtask

    // ctl: [3] stop after command, [2] command, [1] address, [0] data parity fault
    task automatic send_seq(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] d,
                            input int nfr, input logic [3:0] ctl);
        start_seq();
        send_bits({DEFAULT_USID, cmd, ~^{DEFAULT_USID, cmd} ^ ctl[2]}, 13);
        if (ctl[3] || ctl[2]) return;
        if (nfr == 2) begin
            send_bits({4'h0, a, ~^a ^ ctl[1]}, 9);
            if (ctl[1]) return;
        end
        if (nfr > 0) begin
            send_bits({4'h0, d, ~^d ^ ctl[0]}, 9);
            if (ctl[0]) return;
        end
        send_bit(1'b0); // park closes the write
        half_wait();
    endtask

    // read: park rise, nine driven bits sampled before each fall, closing park
    task automatic read_reg(input logic [7:0] cmd, input logic [7:0] a, output logic [7:0] d,
                            output logic p);
        logic [8:0] sh;
        sh = 9'h000;
        start_seq();
        send_bits({DEFAULT_USID, cmd, ~^{DEFAULT_USID, cmd}}, 13);
        // extended read carries its address in a frame of its own
        if (cmd == CMD_EXT_RD) begin
            send_bits({4'h0, a, ~^a}, 9);
        end
        sdata_oe_out = 1'b0;
        send_bit(1'b0);
        for (int i = 0; i < 9; i++) begin
            sclk_out = 1'b1;
            half_wait();
            sh = {sh[7:0], sdata_in};
            sclk_out = 1'b0;
            half_wait();
        end
        send_bit(1'b0);
        half_wait();
        // retake the line at its released level: a fall here would look like a start
        sdata_out = 1'b1;
        sdata_oe_out = 1'b1;
        {d, p} = sh;
    endtask
endmodule

// ### dv/tb_rf_switch_regs.sv
// self-checking bench for the rf switch register bank
`timescale 1ns/1ps
module tb_rf_switch_regs
    import rf_switch_pkg::*;
;
    logic       clk_in;
    logic       reset_n_in;
    wire        sclk_w;
    wire        m_sdata;
    wire        m_oe;
    wire        dut_sdata;
    wire        dut_oe;
    wire        sdata_w;
    wire  [3:0] rf_en;
    int         miscompares;
    int         comparisons;
    logic [3:0] routes [5] = '{ROUTE_ONE, ROUTE_TWO, ROUTE_THREE, ROUTE_FOUR, ROUTE_ISOLATE};

    // released line shows the inverse of the last master value
    assign sdata_w = dut_oe ? dut_sdata : (m_oe ? m_sdata : ~m_sdata);

    rf_switch_regs dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .sclk_in(sclk_w),
        .sdata_in(sdata_w), .sdata_out(dut_sdata), .sdata_oe_out(dut_oe),
        .rf_port_en_out(rf_en));
    serial_master_model m (.clk_in(clk_in), .sdata_in(sdata_w), .sclk_out(sclk_w),
        .sdata_out(m_sdata), .sdata_oe_out(m_oe));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        m.send_seq({CMD_WR_TAG, a[4:0]}, a, d, 1, 4'h0);
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       p;
        m.read_reg({CMD_RD_TAG, a[4:0]}, a, d, p);
        check(name, exp, d);
        check("read parity", {7'h00, ~^d}, {7'h00, p});
    endtask

    // read through the extended command with a separate address frame
    task automatic rd_ext(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       p;
        m.read_reg(CMD_EXT_RD, a, d, p);
        check(name, exp, d);
        check("ext read parity", {7'h00, ~^d}, {7'h00, p});
    endtask

    task automatic rf(input logic [3:0] exp);
        check("rf_port_en", {4'h0, exp}, {4'h0, rf_en});
    endtask

    // all routes with every trigger masked, two of the five by register-zero write
    task automatic t_routes();
        wr(ADDR_TRIG, {2'b00, MASK_ALL, 3'b000});
        for (int i = 0; i < 5; i++) begin
            if (i % 2 == 1) m.send_seq({1'b1, 3'b000, routes[i]}, 8'h00, 8'h00, 0, 4'h0);
            else wr(ADDR_PATH, {4'h0, routes[i]});
            rf(routes[i]);
            rd("path", ADDR_PATH, {4'h0, routes[i]});
        end
    endtask

    // shadow writes wait for a trigger, partial mask still shadows
    task automatic t_trigger();
        wr(ADDR_TRIG, 8'h00);
        wr(ADDR_PATH, {4'h0, ROUTE_THREE});
        wr(ADDR_SPARE, 8'hA5);
        rf(ROUTE_ISOLATE);
        rd("spare", ADDR_SPARE, 8'h00);
        wr(ADDR_TRIG, 8'h04);
        rf(ROUTE_THREE);
        rd("spare", ADDR_SPARE, 8'hA5);
        rd("trig", ADDR_TRIG, 8'h00);
        wr(ADDR_TRIG, 8'h30);
        wr(ADDR_PATH, {4'h0, ROUTE_ONE});
        rf(ROUTE_THREE);
        rd("trig", ADDR_TRIG, 8'h30);
        wr(ADDR_TRIG, 8'h31);
        rf(ROUTE_ONE);
    endtask

    // every error flag raised, held across good traffic, cleared by a read
    task automatic t_errors();
        wr(8'h05, 8'h11);
        rd("bad read", 8'h05, 8'h00);
        m.send_seq({CMD_WR_TAG, 5'h00}, 8'h00, 8'h08, 1, 4'h1);
        m.send_seq(CMD_EXT_WR, ADDR_SPARE, 8'h22, 2, 4'h2);
        m.send_seq({CMD_WR_TAG, 5'h01}, 8'h01, 8'h33, 1, 4'h4);
        m.send_seq({CMD_WR_TAG, 5'h01}, 8'h01, 8'h44, 1, 4'h8);
        wr(ADDR_SPARE, 8'h3C);
        rf(ROUTE_ONE);
        rd("status", ADDR_STATUS, 8'h7E);
        rd("status", ADDR_STATUS, 8'h00);
    endtask

    // software reset returns path, spare and status to their reset values
    task automatic t_soft_reset();
        wr(ADDR_TRIG, {2'b00, MASK_ALL, 3'b000});
        wr(ADDR_PATH, {4'h0, ROUTE_TWO});
        wr(ADDR_SPARE, 8'h5A);
        m.send_seq(CMD_EXT_WR, ADDR_SPARE, 8'hC3, 2, 4'h0);
        rd_ext("ext spare", ADDR_SPARE, 8'hC3);
        wr(8'h07, 8'h00);
        rf(ROUTE_TWO);
        wr(ADDR_STATUS, 8'h80);
        rf(ROUTE_ISOLATE);
        rd("path", ADDR_PATH, RESET_PATH);
        rd("spare", ADDR_SPARE, RESET_SPARE);
        rd("status", ADDR_STATUS, 8'h00);
    endtask

    initial begin
        reset_n_in = 1'b0;
        miscompares = 0;
        comparisons = 0;
        repeat (4) @(negedge clk_in);
        reset_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rf(ROUTE_ISOLATE);
        rd("path", ADDR_PATH, RESET_PATH);
        rd("status", ADDR_STATUS, 8'h00);
        t_routes();
        t_trigger();
        t_errors();
        t_soft_reset();
        final_report();
    end

    // watchdog well beyond the roughly 8400 cycles the tests need
    initial begin
        repeat (30000) @(posedge clk_in);
        miscompares++;
        final_report();
    end
endmodule
